// >>> inc/nls_pkg.sv
// package: operation codes, widths and reset values for the nibble logic/skip unit
package nls_pkg;
	localparam int NIBBLE_W = 4;

	// operation select, one-hot
	typedef enum logic [11:0] {
		NLS_OP_NONE   = 12'h000,
		NLS_OP_OR_RM  = 12'h001,
		NLS_OP_OR_MI  = 12'h002,
		NLS_OP_AND_RM = 12'h004,
		NLS_OP_AND_MI = 12'h008,
		NLS_OP_XOR_RM = 12'h010,
		NLS_OP_XOR_MI = 12'h020,
		NLS_OP_BITS_TRUE  = 12'h040,
		NLS_OP_BITS_FALSE = 12'h080,
		NLS_OP_EQUAL      = 12'h100,
		NLS_OP_UNEQUAL    = 12'h200,
		NLS_OP_GE         = 12'h400,
		NLS_OP_LT         = 12'h800
	} nls_op_e;

	localparam logic [3:0] NIBBLE_ZERO = 4'h0;
	localparam logic       FLAG_RST    = 1'b0;
endpackage

// >>> hdl/nls_unit.sv
// module: execution of nibble logical, bit-test and compare-and-skip operations
`timescale 1ns/1ps

// Summary of operation
// - register OR memory, result to register
// - memory OR immediate, result to memory
// - register AND memory, result to register
// - memory AND immediate, result to memory
// - register XOR memory, result to register
// - memory XOR immediate, result to memory
// - bit-true test clears compare flag, skips
// - bit-false test clears compare flag, skips
// - skipped instruction runs as no operation
// - skip if memory equals immediate
// - skip if memory differs from immediate
// - skip when subtraction has no borrow
// - skip when subtraction has a borrow
// - compare flag: subtract keeps destination, keeps zero flag on zero result
module nls_unit #(
	parameter int DATA_W = 4
) (
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	input  wire logic                 op_valid,
	input  wire nls_pkg::nls_op_e     op_sel,
	input  wire logic [DATA_W-1:0]    reg_data,
	input  wire logic [DATA_W-1:0]    mem_data,
	input  wire logic [DATA_W-1:0]    immediate_nibble,
	input  wire logic                 sub_valid,
	input  wire logic [DATA_W-1:0]    sub_result,
	input  wire logic                 compare_only_flag_set,
	input  wire logic                 zero_flag_set,
	output logic                      reg_we_q,
	output logic [DATA_W-1:0]         reg_wdata_q,
	output logic                      mem_we_q,
	output logic [DATA_W-1:0]         mem_wdata_q,
	output logic                      skip_next_q,
	output logic                      no_operation,
	output logic                      sub_dest_we,
	output logic                      compare_only_flag_q,
	output logic                      zero_flag_q
);
	if (DATA_W != nls_pkg::NIBBLE_W) begin : g_bad_width
		$error("nls_unit: DATA_W must be 4");
	end

	// --------------------------------------------------------------
	// combinational operation results
	// --------------------------------------------------------------
	logic [DATA_W-1:0] rm_or, rm_and, rm_xor, mi_or, mi_and, mi_xor, masked;
	logic [DATA_W:0]   diff;
	logic              borrow, diff_zero, live, skip_d;
	logic              reg_we_d, mem_we_d;
	logic [DATA_W-1:0] reg_wdata_d, mem_wdata_d;

	// per-bit gates so no carry can leak between bits
	for (genvar b = 0; b < DATA_W; b++) begin : g_bit
		assign rm_or[b]  = reg_data[b] | mem_data[b];
		assign rm_and[b] = reg_data[b] & mem_data[b];
		assign rm_xor[b] = reg_data[b] ^ mem_data[b];
		assign mi_or[b]  = mem_data[b] | immediate_nibble[b];
		assign mi_and[b] = mem_data[b] & immediate_nibble[b];
		assign mi_xor[b] = mem_data[b] ^ immediate_nibble[b];
	end

	// unsigned subtract, difference is never stored
	assign masked    = mi_and;
	assign diff      = {1'b0, mem_data} - {1'b0, immediate_nibble};
	assign borrow    = diff[DATA_W];
	assign diff_zero = (diff[DATA_W-1:0] == nls_pkg::NIBBLE_ZERO);
	// a skipped instruction does nothing at all
	assign live         = op_valid && !skip_next_q;
	assign no_operation = op_valid && skip_next_q;

	// result select and skip decision
	always_comb begin
		reg_we_d    = 1'b0;
		mem_we_d    = 1'b0;
		reg_wdata_d = reg_data;
		mem_wdata_d = mem_data;
		skip_d      = 1'b0;
		unique case (op_sel)
			nls_pkg::NLS_OP_NONE: ;
			nls_pkg::NLS_OP_OR_RM: begin
				reg_we_d    = live;
				reg_wdata_d = rm_or;
			end
			nls_pkg::NLS_OP_OR_MI: begin
				mem_we_d    = live;
				mem_wdata_d = mi_or;
			end
			nls_pkg::NLS_OP_AND_RM: begin
				reg_we_d    = live;
				reg_wdata_d = rm_and;
			end
			nls_pkg::NLS_OP_AND_MI: begin
				mem_we_d    = live;
				mem_wdata_d = mi_and;
			end
			nls_pkg::NLS_OP_XOR_RM: begin
				reg_we_d    = live;
				reg_wdata_d = rm_xor;
			end
			nls_pkg::NLS_OP_XOR_MI: begin
				mem_we_d    = live;
				mem_wdata_d = mi_xor;
			end
			nls_pkg::NLS_OP_BITS_TRUE: begin
				skip_d = live && (masked == immediate_nibble);
			end
			nls_pkg::NLS_OP_BITS_FALSE: begin
				skip_d = live && (masked == nls_pkg::NIBBLE_ZERO);
			end
			nls_pkg::NLS_OP_EQUAL:   skip_d = live && diff_zero;
			nls_pkg::NLS_OP_UNEQUAL: skip_d = live && !diff_zero;
			nls_pkg::NLS_OP_GE:      skip_d = live && !borrow;
			nls_pkg::NLS_OP_LT:      skip_d = live && borrow;
			default: ; // non one-hot code: ignored
		endcase
	end

	// --------------------------------------------------------------
	// write-back strobes; skip ops never write memory
	// --------------------------------------------------------------
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reg_we_q    <= 1'b0;
			reg_wdata_q <= nls_pkg::NIBBLE_ZERO;
			mem_we_q    <= 1'b0;
			mem_wdata_q <= nls_pkg::NIBBLE_ZERO;
		end else begin
			reg_we_q    <= reg_we_d;
			reg_wdata_q <= reg_wdata_d;
			mem_we_q    <= mem_we_d;
			mem_wdata_q <= mem_wdata_d;
		end
	end

	// skip flag: held until the next instruction is consumed as no-op
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			skip_next_q <= nls_pkg::FLAG_RST;
		end else if (op_valid) begin
			skip_next_q <= skip_d;
		end
	end

	// --------------------------------------------------------------
	// compare and zero flags
	// --------------------------------------------------------------
	// destination write of a subtract is blocked in compare mode
	assign sub_dest_we = sub_valid && !compare_only_flag_q;

	// bit-test decode, shared by the flag logic and its check
	function automatic logic is_bit_test(input nls_pkg::nls_op_e op);
		return op == nls_pkg::NLS_OP_BITS_TRUE || op == nls_pkg::NLS_OP_BITS_FALSE;
	endfunction

	// bit tests clear compare flag; the clear wins only over a same-cycle set
	// from the decoder when a bit test actually executes
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			compare_only_flag_q <= nls_pkg::FLAG_RST;
		end else if (live && is_bit_test(op_sel)) begin
			compare_only_flag_q <= 1'b0;
		end else if (compare_only_flag_set) begin
			compare_only_flag_q <= 1'b1;
		end
	end

	// zero flag: cleared on nonzero, kept on zero when comparing
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			zero_flag_q <= nls_pkg::FLAG_RST;
		end else if (sub_valid) begin
			if (sub_result != nls_pkg::NIBBLE_ZERO) begin
				zero_flag_q <= 1'b0;
			end else if (!compare_only_flag_q) begin
				zero_flag_q <= 1'b1;
			end
		end else if (zero_flag_set) begin
			zero_flag_q <= 1'b1;
		end
	end

	// --------------------------------------------------------------
	// checks
	// --------------------------------------------------------------
	chk_or_reg_result: assert property (@(posedge mclk) disable iff (!rstn)
		live && op_sel == nls_pkg::NLS_OP_OR_RM |=> reg_we_q &&
		reg_wdata_q == ($past(reg_data) | $past(mem_data)))
		else $error("register OR result wrong");
	chk_or_mem_result: assert property (@(posedge mclk) disable iff (!rstn)
		live && op_sel == nls_pkg::NLS_OP_OR_MI |=> mem_we_q &&
		mem_wdata_q == ($past(mem_data) | $past(immediate_nibble)))
		else $error("memory OR result wrong");
	chk_and_reg_result: assert property (@(posedge mclk) disable iff (!rstn)
		live && op_sel == nls_pkg::NLS_OP_AND_RM |=> reg_we_q &&
		reg_wdata_q == ($past(reg_data) & $past(mem_data)))
		else $error("register AND result wrong");
	chk_and_mem_result: assert property (@(posedge mclk) disable iff (!rstn)
		live && op_sel == nls_pkg::NLS_OP_AND_MI |=> mem_we_q &&
		mem_wdata_q == ($past(mem_data) & $past(immediate_nibble)))
		else $error("memory AND result wrong");
	chk_xor_reg_result: assert property (@(posedge mclk) disable iff (!rstn)
		live && op_sel == nls_pkg::NLS_OP_XOR_RM |=> reg_we_q &&
		reg_wdata_q == ($past(reg_data) ^ $past(mem_data)))
		else $error("register XOR result wrong");
	chk_xor_mem_result: assert property (@(posedge mclk) disable iff (!rstn)
		live && op_sel == nls_pkg::NLS_OP_XOR_MI |=> mem_we_q &&
		mem_wdata_q == ($past(mem_data) ^ $past(immediate_nibble)))
		else $error("memory XOR result wrong");
	chk_bit_test_compare: assert property (@(posedge mclk) disable iff (!rstn)
		live && is_bit_test(op_sel)
		|=> !compare_only_flag_q && skip_next_q ==
		($past(op_sel) == nls_pkg::NLS_OP_BITS_TRUE ?
		(($past(mem_data) & $past(immediate_nibble)) == $past(immediate_nibble)) :
		(($past(mem_data) & $past(immediate_nibble)) == 4'h0)))
		else $error("bit test skip or compare flag wrong");
	chk_skipped_noop: assert property (@(posedge mclk) disable iff (!rstn)
		skip_next_q && op_valid |=> !reg_we_q && !mem_we_q && !skip_next_q)
		else $error("skipped instruction had an effect");
	chk_equal_skip: assert property (@(posedge mclk) disable iff (!rstn)
		live && op_sel == nls_pkg::NLS_OP_EQUAL |=>
		skip_next_q == ($past(mem_data) == $past(immediate_nibble)) && !mem_we_q)
		else $error("equal skip wrong");
	chk_unequal_skip: assert property (@(posedge mclk) disable iff (!rstn)
		live && op_sel == nls_pkg::NLS_OP_UNEQUAL |=>
		skip_next_q == ($past(mem_data) != $past(immediate_nibble)))
		else $error("unequal skip wrong");
	chk_ge_skip: assert property (@(posedge mclk) disable iff (!rstn)
		live && op_sel == nls_pkg::NLS_OP_GE |=>
		skip_next_q == ($past(mem_data) >= $past(immediate_nibble)))
		else $error("greater-or-equal skip wrong");
	chk_lt_skip: assert property (@(posedge mclk) disable iff (!rstn)
		live && op_sel == nls_pkg::NLS_OP_LT |=>
		skip_next_q == ($past(mem_data) < $past(immediate_nibble)))
		else $error("less-than skip wrong");
	chk_compare_zero_keep: assert property (@(posedge mclk) disable iff (!rstn)
		sub_valid && compare_only_flag_q && sub_result == 4'h0
		|-> !sub_dest_we ##1 zero_flag_q == $past(zero_flag_q))
		else $error("compare mode zero flag not kept");
	chk_nonzero_zero_clear: assert property (@(posedge mclk) disable iff (!rstn)
		sub_valid && sub_result != 4'h0 |=> !zero_flag_q)
		else $error("nonzero result left zero flag set");
	chk_skip_no_write: assert property (@(posedge mclk) disable iff (!rstn)
		op_valid && op_sel inside {nls_pkg::NLS_OP_EQUAL, nls_pkg::NLS_OP_UNEQUAL,
		nls_pkg::NLS_OP_GE, nls_pkg::NLS_OP_LT, nls_pkg::NLS_OP_BITS_TRUE,
		nls_pkg::NLS_OP_BITS_FALSE} |=> !mem_we_q && !reg_we_q)
		else $error("skip op wrote data");

	cov_skip_taken:  cover property (@(posedge mclk) disable iff (!rstn)
		live && skip_d ##1 no_operation);
	cov_or_write:    cover property (@(posedge mclk) disable iff (!rstn)
		live && op_sel == nls_pkg::NLS_OP_OR_RM);
	cov_compare_chain: cover property (@(posedge mclk) disable iff (!rstn)
		sub_valid && compare_only_flag_q ##1 sub_valid && compare_only_flag_q);
endmodule // nls_unit

// >>> tb/test_nibble_logic_skip_unit.sv
// testbench: self-checking scenarios for the nibble logic and skip unit
`timescale 1ns/1ps

module test_nibble_logic_skip_unit;
	logic             mclk = 1'b0;
	logic             rstn = 1'b0;
	logic             op_valid = 1'b0;
	nls_pkg::nls_op_e op_sel = nls_pkg::NLS_OP_NONE;
	logic [3:0]       reg_data = 4'h0;
	logic [3:0]       mem_data = 4'h0;
	logic [3:0]       immediate_nibble = 4'h0;
	logic             sub_valid = 1'b0;
	logic [3:0]       sub_result = 4'h0;
	logic             compare_only_flag_set = 1'b0;
	logic             zero_flag_set = 1'b0;
	logic             reg_we_q, mem_we_q, skip_next_q, no_operation, sub_dest_we;
	logic             compare_only_flag_q, zero_flag_q;
	logic [3:0]       reg_wdata_q, mem_wdata_q;
	int               err_count = 0;
	int               tests_run = 0;
	int               cycles = 0;

	nls_unit DUT (.mclk(mclk), .rstn(rstn), .op_valid(op_valid), .op_sel(op_sel),
		.reg_data(reg_data), .mem_data(mem_data), .immediate_nibble(immediate_nibble),
		.sub_valid(sub_valid), .sub_result(sub_result),
		.compare_only_flag_set(compare_only_flag_set), .zero_flag_set(zero_flag_set),
		.reg_we_q(reg_we_q), .reg_wdata_q(reg_wdata_q), .mem_we_q(mem_we_q),
		.mem_wdata_q(mem_wdata_q), .skip_next_q(skip_next_q), .no_operation(no_operation),
		.sub_dest_we(sub_dest_we), .compare_only_flag_q(compare_only_flag_q),
		.zero_flag_q(zero_flag_q));

	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	always #50 mclk = ~mclk;
	// scenarios need well under a hundred cycles, so this ceiling means a hang
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 1000) begin
			err_count++;
			summarize();
		end
	end

	// ----------------------------------------
	// compare, drive and report helpers
	// ----------------------------------------
	task automatic chk1(input logic got, input logic exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s got %b exp %b", $time, what, got, exp);
		end
	endtask
	task automatic chk4(input logic [3:0] got, input logic [3:0] exp, input string what);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	// leaves op_valid up so operations can run back to back
	task automatic issue(input nls_pkg::nls_op_e s, input logic [3:0] r, m, i);
		op_valid = 1'b1;
		op_sel = s;
		reg_data = r;
		mem_data = m;
		immediate_nibble = i;
		@(posedge mclk);
		#1;
	endtask
	task automatic idle();
		op_valid = 1'b0;
		@(posedge mclk);
		#1;
	endtask
	task automatic lg(input nls_pkg::nls_op_e s, input logic to_reg, input logic [3:0] e);
		issue(s, 4'hA, 4'h6, 4'hC);
		chk1(reg_we_q, to_reg, "register strobe");
		chk1(mem_we_q, !to_reg, "memory strobe");
		chk4(to_reg ? reg_wdata_q : mem_wdata_q, e, "logic result");
	endtask
	// a skip test followed at once by a register op, which must be suppressed if met
	task automatic sk(input nls_pkg::nls_op_e s, input logic [3:0] m, i, input logic e);
		issue(s, 4'h3, m, i);
		chk1(skip_next_q, e, "skip decision");
		chk1(mem_we_q, 1'b0, "memory untouched");
		chk1(reg_we_q, 1'b0, "register untouched");
		op_sel = nls_pkg::NLS_OP_OR_RM;
		#1;
		chk1(no_operation, e, "suppress marker");
		@(posedge mclk);
		#1;
		chk1(reg_we_q, !e, "follower write");
		chk1(skip_next_q, 1'b0, "skip consumed");
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_logic();
		lg(nls_pkg::NLS_OP_OR_RM, 1'b1, 4'hE);
		lg(nls_pkg::NLS_OP_OR_MI, 1'b0, 4'hE);
		lg(nls_pkg::NLS_OP_AND_RM, 1'b1, 4'h2);
		lg(nls_pkg::NLS_OP_AND_MI, 1'b0, 4'h4);
		lg(nls_pkg::NLS_OP_XOR_RM, 1'b1, 4'hC);
		lg(nls_pkg::NLS_OP_XOR_MI, 1'b0, 4'hA);
		idle();
		$display("logic ops done");
	endtask
	task automatic t_skip();
		sk(nls_pkg::NLS_OP_BITS_TRUE, 4'hB, 4'h3, 1'b1);
		sk(nls_pkg::NLS_OP_BITS_TRUE, 4'hB, 4'h4, 1'b0);
		sk(nls_pkg::NLS_OP_BITS_FALSE, 4'hB, 4'h4, 1'b1);
		sk(nls_pkg::NLS_OP_BITS_FALSE, 4'hB, 4'h1, 1'b0);
		sk(nls_pkg::NLS_OP_EQUAL, 4'h5, 4'h5, 1'b1);
		sk(nls_pkg::NLS_OP_EQUAL, 4'h5, 4'h6, 1'b0);
		sk(nls_pkg::NLS_OP_UNEQUAL, 4'h5, 4'h6, 1'b1);
		sk(nls_pkg::NLS_OP_UNEQUAL, 4'hF, 4'hF, 1'b0);
		sk(nls_pkg::NLS_OP_GE, 4'h7, 4'h7, 1'b1);
		sk(nls_pkg::NLS_OP_GE, 4'h6, 4'h7, 1'b0);
		sk(nls_pkg::NLS_OP_LT, 4'h0, 4'h1, 1'b1);
		sk(nls_pkg::NLS_OP_LT, 4'hF, 4'h0, 1'b0);
		idle();
		$display("skip ops done");
	endtask
	task automatic t_flags();
		compare_only_flag_set = 1'b1;
		zero_flag_set = 1'b1;
		@(posedge mclk);
		#1;
		compare_only_flag_set = 1'b0;
		zero_flag_set = 1'b0;
		sub_valid = 1'b1;
		#1;
		chk1(sub_dest_we, 1'b0, "destination held");
		@(posedge mclk);
		#1;
		chk1(zero_flag_q, 1'b1, "zero kept");
		sub_result = 4'h3;
		@(posedge mclk);
		#1;
		sub_valid = 1'b0;
		chk1(zero_flag_q, 1'b0, "zero cleared");
		issue(nls_pkg::NLS_OP_BITS_TRUE, 4'h0, 4'hF, 4'hF);
		chk1(compare_only_flag_q, 1'b0, "bit-true clears");
		issue(nls_pkg::NLS_OP_OR_RM, 4'h0, 4'h0, 4'h0);
		compare_only_flag_set = 1'b1;
		issue(nls_pkg::NLS_OP_BITS_FALSE, 4'h0, 4'hF, 4'hF);
		compare_only_flag_set = 1'b0;
		chk1(compare_only_flag_q, 1'b0, "bit-false clears");
		chk1(skip_next_q, 1'b0, "bit-false not met");
		op_valid = 1'b0;
		sub_valid = 1'b1;
		sub_result = 4'h0;
		#1;
		chk1(sub_dest_we, 1'b1, "destination written");
		@(posedge mclk);
		#1;
		sub_valid = 1'b0;
		chk1(zero_flag_q, 1'b1, "zero set");
		$display("flag handling done");
	endtask

	// a skipped instruction must neither clear the compare flag, arm a new skip nor write memory
	task automatic t_suppress();
		compare_only_flag_set = 1'b1;
		@(posedge mclk);
		#1;
		compare_only_flag_set = 1'b0;
		issue(nls_pkg::NLS_OP_EQUAL, 4'h0, 4'h9, 4'h9);
		chk1(skip_next_q, 1'b1, "equal skip armed");
		issue(nls_pkg::NLS_OP_BITS_TRUE, 4'h0, 4'hF, 4'hF);
		chk1(compare_only_flag_q, 1'b1, "skipped test keeps compare");
		chk1(skip_next_q, 1'b0, "skipped test sets no skip");
		issue(nls_pkg::NLS_OP_LT, 4'h0, 4'h2, 4'h3);
		chk1(skip_next_q, 1'b1, "less-than skip armed");
		issue(nls_pkg::NLS_OP_OR_MI, 4'h0, 4'h1, 4'h8);
		chk1(mem_we_q, 1'b0, "skipped memory write");
		idle();
		$display("suppression done");
	endtask

	// main sequence: reset for two cycles, then each scenario in turn
	initial begin
		repeat (2) @(posedge mclk);
		#1;
		rstn = 1'b1;
		chk1(skip_next_q, 1'b0, "reset skip");
		chk1(compare_only_flag_q, 1'b0, "reset compare flag");
		t_logic();
		t_skip();
		t_flags();
		t_suppress();
		summarize();
	end
endmodule // test_nibble_logic_skip_unit
